// *** include/cwd_pkg.sv ***
// shared constants and types for the counter watchdog channel
package cwd_pkg;

  // core clock and derived timing
  localparam int unsigned CORE_CLK_HZ = 40_000_000;
  localparam int unsigned CORE_PERIOD_NS = 25;
  localparam int unsigned INT_CLK_HZ = 20_000_000;
  localparam int unsigned INT_CLK_DIV = CORE_CLK_HZ / INT_CLK_HZ;
  localparam int unsigned DEBOUNCE_TIME_NS = 200;
  // least time, so round up to whole cycles
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  // register byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_CTL = 8'h30;
  localparam logic [7:0] ADDR_CONSTA = 8'h70;

  // control field encodings
  localparam logic [2:0] MODE_WATCHDOG = 3'h3;
  localparam logic [1:0] RELOAD_HIGH = 2'h2;
  localparam logic [1:0] RELOAD_LOW = 2'h1;
  localparam logic [1:0] BCLK_ENABLE = 2'h1;
  localparam logic [1:0] TRIG_LOW = 2'h1;
  localparam logic [1:0] TRIG_HIGH = 2'h2;
  localparam logic [2:0] CLKSEL_EXT = 3'h5;

  // reset values
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [31:0] CONSTA_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // interrupt status bits
  localparam int unsigned STAT_W = 3;
  localparam int unsigned STAT_TIMEOUT = 0;
  localparam int unsigned STAT_SEQ_ERR = 1;
  localparam int unsigned STAT_KICK = 2;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // channel control register, bit 15 down to bit 0
  typedef struct packed {
    logic irq_en;
    logic wide;
    logic debounce;
    logic [2:0] clk_sel;
    logic [1:0] trig_sel;
    logic [1:0] bclk_sel;
    logic [1:0] reload_sel;
    logic out_high;
    logic [2:0] mode;
  } cwd_ctl_t;

  typedef enum logic [1:0] {
    WD_IDLE,
    WD_LOADED,
    WD_RUNNING,
    WD_EXPIRED
  } cwd_wd_state_t;

endpackage

// *** src/cwd_input_cond.sv ***
// field input synchroniser with optional debounce
`timescale 1ns/1ps
`default_nettype none
module cwd_input_cond
  import cwd_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // pin side
  input wire logic i_pin,
  input wire logic i_deb_en,
  // conditioned level
  output logic o_level
);

  localparam int unsigned CW = $clog2(DEB_CYC + 1);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic [CW-1:0] cnt;
  } cwd_cond_state_t;

  cwd_cond_state_t q, d;

  // sync1 feeds only sync2; filter looks at sync2
  always_comb begin
    d = q;
    d.sync1 = i_pin;
    d.sync2 = q.sync1;
    if (!i_deb_en) begin
      d.level = q.sync2;
      d.cnt = '0;
    end else if (q.sync2 == q.level) begin
      d.cnt = '0;
    end else if (q.cnt == CW'(DEB_CYC - 1)) begin
      // stable long enough, accept the new level
      d.level = q.sync2;
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.level;

endmodule
`default_nettype wire

// *** src/cwd_countdown.sv ***
// loadable down counter with expiry detect
`timescale 1ns/1ps
`default_nettype none
module cwd_countdown
  import cwd_pkg::*;
#(
  parameter int unsigned W = 32
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  input wire logic i_dec,
  // status
  output logic [W-1:0] o_count,
  output logic o_expire
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } cwd_cnt_state_t;

  cwd_cnt_state_t q, d;

  // load wins over decrement; stops at zero
  always_comb begin
    d = q;
    if (i_load) begin
      d.cnt = i_load_val;
    end else if (i_dec && (q.cnt != '0)) begin
      d.cnt = q.cnt - W'(1);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // count at one or zero: the next decrement reaches or holds zero
  // kept free of i_dec so the caller can gate its decrement on it
  assign o_expire = (q.cnt <= W'(1));
  assign o_count = q.cnt;

endmodule
`default_nettype wire

// *** src/cwd_watchdog.sv ***
// watchdog counter channel with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module cwd_watchdog
  import cwd_pkg::*;
#(
  parameter int unsigned CNT_W = 32,
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC,
  parameter int unsigned CLK_DIV = INT_CLK_DIV
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // axi4-lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  // axi4-lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  // axi4-lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // field inputs
  input wire logic i_channel_a_input,
  input wire logic i_channel_b_input,
  input wire logic i_channel_c_input,
  // field output and interrupt
  output logic o_counter_three_output,
  output logic o_irq
);

  localparam int unsigned DIV_W = (CLK_DIV > 1) ? $clog2(CLK_DIV) : 1;

  typedef struct packed {
    // bus slave
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // registers
    logic board_irq_en;
    cwd_ctl_t ctl;
    logic [31:0] consta;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    // channel engine
    cwd_wd_state_t wd;
    logic trig_prev;
    logic bclk_prev;
    logic [DIV_W-1:0] div;
    logic out;
  } cwd_state_t;

  localparam cwd_state_t RST_Q = '{
    aw_have: 1'b0, aw_addr: '0, w_have: 1'b0, w_data: WORD_ZERO, w_strb: 4'h0,
    bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: WORD_ZERO, rresp: RESP_OKAY,
    board_irq_en: 1'b0, ctl: CTL_RST, consta: CONSTA_RST, status: '0, mask: '0,
    wd: WD_IDLE, trig_prev: 1'b0, bclk_prev: 1'b0, div: '0, out: 1'b1
  };

  cwd_state_t q, d;

  logic a_lvl, b_lvl, c_lvl;
  logic reload_act, trig_act, trig_rise, bclk_rise, int_tick, tick, wd_mode;
  logic cnt_load, cnt_dec, cnt_expire;
  logic [CNT_W-1:0] cnt_load_val, cnt_value;
  logic ev_timeout, ev_seq_err, ev_kick;
  logic [STAT_W-1:0] stat_set, stat_clr;

  cwd_input_cond #(.DEB_CYC(DEB_CYC)) u_cond_a (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_channel_a_input),
    .i_deb_en(q.ctl.debounce),
    .o_level(a_lvl)
  );

  // clock input is never debounced, edges matter
  cwd_input_cond #(.DEB_CYC(DEB_CYC)) u_cond_b (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_channel_b_input),
    .i_deb_en(1'b0),
    .o_level(b_lvl)
  );

  cwd_input_cond #(.DEB_CYC(DEB_CYC)) u_cond_c (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_channel_c_input),
    .i_deb_en(q.ctl.debounce),
    .o_level(c_lvl)
  );

  cwd_countdown #(.W(CNT_W)) u_count (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_load(cnt_load),
    .i_load_val(cnt_load_val),
    .i_dec(cnt_dec),
    .o_count(cnt_value),
    .o_expire(cnt_expire)
  );

  // byte-lane merge for writes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // field decode of the input selections
  always_comb begin
    wd_mode = (q.ctl.mode == MODE_WATCHDOG);
    // reload polarity, 10 high, 01 low, else off
    case (q.ctl.reload_sel)
      RELOAD_HIGH: reload_act = a_lvl;
      RELOAD_LOW: reload_act = !a_lvl;
      default: reload_act = 1'b0;
    endcase
    // trigger polarity, 01 low, 10 high, else off
    case (q.ctl.trig_sel)
      TRIG_LOW: trig_act = !c_lvl;
      TRIG_HIGH: trig_act = c_lvl;
      default: trig_act = 1'b0;
    endcase
    trig_rise = trig_act && !q.trig_prev;
    // external clock edges only when input b enabled
    bclk_rise = (q.ctl.bclk_sel == BCLK_ENABLE) && b_lvl && !q.bclk_prev;
    int_tick = (q.div == DIV_W'(CLK_DIV - 1));
    // external source replaces the internal tick
    tick = (q.ctl.clk_sel == CLKSEL_EXT) ? bclk_rise : int_tick;
  end

  // short counter keeps only the low half of constant A
  // only constant A feeds the load value
  assign cnt_load_val = q.ctl.wide ? CNT_W'(q.consta) : CNT_W'(q.consta[15:0]);

  // bus handshakes; a pending response blocks new writes
  assign o_awready = !q.aw_have && !q.bvalid;
  assign o_wready = !q.w_have && !q.bvalid;
  assign o_arready = !q.rvalid;

  // main next-state logic
  always_comb begin
    d = q;
    cnt_load = 1'b0;
    cnt_dec = 1'b0;
    ev_timeout = 1'b0;
    ev_seq_err = 1'b0;
    ev_kick = 1'b0;
    stat_clr = '0;

    // internal tick divider
    d.div = int_tick ? '0 : q.div + DIV_W'(1);
    d.trig_prev = trig_act;
    d.bclk_prev = b_lvl;

    // watchdog sequence
    if (!wd_mode) begin
      d.wd = WD_IDLE;
    end else if (reload_act) begin
      // reload holds the count at constant A
      cnt_load = 1'b1;
      ev_kick = (q.wd == WD_RUNNING);
      d.wd = WD_LOADED;
    end else begin
      case (q.wd)
        WD_LOADED: begin
          if (trig_rise) begin
            d.wd = WD_RUNNING;
          end
        end
        WD_RUNNING: begin
          // one step per selected clock period
          if (tick) begin
            cnt_dec = 1'b1;
            if (cnt_expire) begin
              d.wd = WD_EXPIRED;
              ev_timeout = 1'b1;
            end
          end
        end
        WD_IDLE, WD_EXPIRED: begin
          // trigger without a prior reload is flagged
          if (trig_rise) begin
            ev_seq_err = 1'b1;
          end
        end
        default: d.wd = WD_IDLE;
      endcase
    end

    d.out = (d.wd == WD_EXPIRED) ? q.ctl.out_high : !q.ctl.out_high;

    // capture write address and data in either order
    if (i_awvalid && o_awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      d.w_have = 1'b1;
      d.w_data = i_wdata;
      d.w_strb = i_wstrb;
    end

    // commit once both halves are here
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (q.aw_addr)
        ADDR_IRQ_EN: begin
          if (q.w_strb[0]) begin
            d.board_irq_en = q.w_data[0];
          end
        end
        ADDR_IRQ_STAT: begin
          // write one to clear
          if (q.w_strb[0]) begin
            stat_clr = q.w_data[STAT_W-1:0];
          end
        end
        ADDR_IRQ_MASK: begin
          if (q.w_strb[0]) begin
            d.mask = q.w_data[STAT_W-1:0];
          end
        end
        // control register
        // register is 16 bits, the upper half of the word is dropped
        ADDR_CTL: d.ctl = cwd_ctl_t'(16'(merge_strb({16'h0000, q.ctl}, q.w_data, q.w_strb)));
        ADDR_CONSTA: d.consta = merge_strb(q.consta, q.w_data, q.w_strb);
        ADDR_COUNT: d.bresp = RESP_OKAY;
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && i_bready) begin
      d.bvalid = 1'b0;
    end

    // reads answer in the cycle after the address is taken
    if (i_arvalid && o_arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      case (i_araddr)
        ADDR_IRQ_EN: d.rdata = {31'h0000_0000, q.board_irq_en};
        ADDR_IRQ_STAT: d.rdata = 32'(q.status);
        ADDR_IRQ_MASK: d.rdata = 32'(q.mask);
        ADDR_COUNT: d.rdata = 32'(cnt_value);
        ADDR_CTL: d.rdata = {16'h0000, q.ctl};
        ADDR_CONSTA: d.rdata = q.consta;
        default: begin
          d.rdata = WORD_ZERO;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && i_rready) begin
      d.rvalid = 1'b0;
    end

    // sticky status, a new event beats a same-cycle clear
    stat_set = '0;
    stat_set[STAT_TIMEOUT] = ev_timeout;
    stat_set[STAT_SEQ_ERR] = ev_seq_err;
    stat_set[STAT_KICK] = ev_kick;
    d.status = (q.status & ~stat_clr) | stat_set;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q <= RST_Q;
    end else begin
      q <= d;
    end
  end

  // bus outputs straight from state
  assign o_bvalid = q.bvalid;
  assign o_bresp = q.bresp;
  assign o_rvalid = q.rvalid;
  assign o_rdata = q.rdata;
  assign o_rresp = q.rresp;
  assign o_counter_three_output = q.out;

  // both channel and board enables gate the line
  assign o_irq = q.board_irq_en && q.ctl.irq_en && (|(q.status & q.mask));

endmodule
`default_nettype wire

// *** verification/cwd_watchdog_monitor.sv ***
// bus and register checks at the watchdog channel ports
`timescale 1ns/1ps
`default_nettype none
module cwd_watchdog_monitor
  import cwd_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // write side
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  // read side
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // addresses that hold a register
  wire logic mapped = i_araddr inside {ADDR_IRQ_EN, ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_COUNT, ADDR_CTL, ADDR_CONSTA};

  // handshake steps
  sequence s_wr_both;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_take;
    i_arvalid && o_arready;
  endsequence

  property p_wr_resp;
    s_wr_both |-> ##[1:2] o_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_b_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_block;
    o_bvalid |-> !o_awready && !o_wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken while answering");
  property p_rd_resp;
    s_rd_take |=> o_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_r_block;
    o_rvalid |-> !o_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read taken while answering");
  property p_ctl_upper;
    s_rd_take ##0 (i_araddr == ADDR_CTL) |=> o_rdata[31:16] == 16'h0000;
  endproperty
  a_ctl_upper: assert property (p_ctl_upper) else $error("control upper half not zero");
  property p_unmapped;
    s_rd_take ##0 !mapped |=> o_rresp == RESP_SLVERR && o_rdata == WORD_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule
`default_nettype wire

// *** verification/cwd_field_model.sv ***
// field side: reload, trigger and external count clock pins
`timescale 1ns/1ps
`default_nettype none
module cwd_field_model (
  // alignment clock
  input wire logic i_core_clk,
  // field pins
  output logic o_reload,
  output logic o_ext_clk,
  output logic o_trig_n
);
  // idle levels, link clock stands still
  initial begin
    o_reload = 1'b0;
    o_ext_clk = 1'b0;
    o_trig_n = 1'b1;
  end
  // pins move away from core edges so sampling never races
  task automatic pulse(input bit trig, input int ns);
    @(posedge i_core_clk);
    #5;
    if (trig) o_trig_n = 1'b0;
    else o_reload = 1'b1;
    #(ns);
    o_trig_n = 1'b1;
    o_reload = 1'b0;
    #(ns);
  endtask
  task automatic frame(input int ns);
    pulse(1'b0, ns);
    pulse(1'b1, ns);
  endtask
  // link clock only while run_clk runs, after a frame, 200 ns period
  task automatic run_clk(input int n);
    @(posedge i_core_clk);
    #5;
    repeat (n) begin
      #100 o_ext_clk = 1'b1;
      #100 o_ext_clk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** verification/cwd_watchdog_tb.sv ***
// self-checking bench for the watchdog channel
`timescale 1ns/1ps
`default_nettype none
module cwd_watchdog_tb;
  import cwd_pkg::*;
  int fail_count = 0;
  int comparisons = 0;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [3:0] i_wstrb = 4'hF;
  logic [2:0] i_awprot = 3'h0, i_arprot = 3'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_counter_three_output, o_irq;
  logic [1:0] o_bresp, o_rresp, resp_q;
  logic [31:0] o_rdata, rd_q;
  wire logic i_channel_a_input, i_channel_b_input, i_channel_c_input;

  // 40 MHz core clock
  always #12.5 i_core_clk = ~i_core_clk;

  cwd_watchdog dut (.i_core_clk, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr, .i_awprot,
    .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
    .i_arvalid, .o_arready, .i_araddr, .i_arprot, .o_rvalid, .i_rready, .o_rdata, .o_rresp,
    .i_channel_a_input, .i_channel_b_input, .i_channel_c_input, .o_counter_three_output, .o_irq);
  cwd_field_model u_fld (.i_core_clk, .o_reload(i_channel_a_input), .o_ext_clk(i_channel_b_input),
    .o_trig_n(i_channel_c_input));

  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // a used-up wait counts as a mismatch
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      finish_test();
    end
  endtask
  // write: both channels offered, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_core_clk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_core_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) break;
    end
    tmo(n, 40);
    resp_q = o_bresp;
    i_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge i_core_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_core_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) break;
    end
    tmo(n, 40);
    rd_q = o_rdata;
    resp_q = o_rresp;
    i_rready <= 1'b0;
  endtask

  // reset values and refused addresses
  task automatic t_reset();
    rd(ADDR_CTL);
    chk("ctl", rd_q, {16'h0000, CTL_RST});
    rd(ADDR_CONSTA);
    chk("consta", rd_q, CONSTA_RST);
    chk("out", 32'(o_counter_three_output), 32'h1);
    chk("irq", 32'(o_irq), 32'h0);
    rd(8'h40);
    chk("rresp", 32'(resp_q), 32'(RESP_SLVERR));
    wr(8'h44, 32'h1234_5678);
    chk("bresp", 32'(resp_q), 32'(RESP_SLVERR));
  endtask
  // external clock, active high output, then trigger with no reload
  task automatic t_ext();
    wr(ADDR_CTL, 32'hFFFF_F56B);
    rd(ADDR_CTL);
    chk("ctl", rd_q, 32'h0000_F56B);
    wr(ADDR_CONSTA, 32'h8000_0005);
    rd(ADDR_CONSTA);
    chk("consta", rd_q, 32'h8000_0005);
    wr(ADDR_CONSTA, 32'h0000_0005);
    wr(ADDR_IRQ_EN, 32'h0000_0001);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    u_fld.frame(500);
    chk("out", 32'(o_counter_three_output), 32'h0);
    u_fld.run_clk(4);
    repeat (8) @(posedge i_core_clk);
    chk("out", 32'(o_counter_three_output), 32'h0);
    rd(ADDR_COUNT);
    chk("count", rd_q, 32'h0000_0001);
    u_fld.run_clk(1);
    repeat (8) @(posedge i_core_clk);
    chk("out", 32'(o_counter_three_output), 32'h1);
    chk("irq", 32'(o_irq), 32'h1);
    u_fld.pulse(1'b1, 500);
    rd(ADDR_IRQ_STAT);
    chk("stat", rd_q, 32'h0000_0003);
    wr(ADDR_IRQ_STAT, 32'h0000_0003);
    chk("irq", 32'(o_irq), 32'h0);
  endtask
  // internal 20 MHz tick, active low output, mask and board enable
  task automatic t_int();
    int n;
    wr(ADDR_CTL, 32'h0000_E163);
    wr(ADDR_CONSTA, 32'h0000_0064);
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    u_fld.frame(500);
    repeat (100) @(posedge i_core_clk);
    chk("out", 32'(o_counter_three_output), 32'h1);
    for (n = 0; n < 150 && o_counter_three_output !== 1'b0; n++) @(posedge i_core_clk);
    tmo(n, 150);
    chk("irq", 32'(o_irq), 32'h0);
    u_fld.pulse(1'b0, 100);
    chk("out", 32'(o_counter_three_output), 32'h0);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    chk("irq", 32'(o_irq), 32'h1);
    wr(ADDR_IRQ_EN, 32'h0000_0000);
    chk("irq", 32'(o_irq), 32'h0);
    wr(ADDR_CTL, 32'h0000_E160);
    repeat (2) @(posedge i_core_clk);
    chk("out", 32'(o_counter_three_output), 32'h1);
    // narrow counter keeps only the low half of constant A
    wr(ADDR_CTL, 32'h0000_A163);
    wr(ADDR_CONSTA, 32'h0001_0003);
    u_fld.pulse(1'b0, 500);
    rd(ADDR_COUNT);
    chk("count", rd_q, 32'h0000_0003);
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_ext();
    t_int();
    finish_test();
  end
endmodule

bind cwd_watchdog cwd_watchdog_monitor u_mon (.i_core_clk, .i_rst_n, .i_awvalid, .o_awready, .i_wvalid,
  .o_wready, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready,
  .o_rdata, .o_rresp);
`default_nettype wire
